/* File: verilog/afsb_top.sv */
// How it works
// - equal widths, both ports: D+1-m writes
// - write-only or 18to9: D-m writes
// - 9to18 input: twice D+1-m writes, twice D-m when write-only
// - default offset 8, or 128 if strapped
// - flag low 2 clocks, high 1 clock
// - bus bit low 2, high 1 clock
// - queue switch may add one clock
// - eight-bit bus shows eight queue states
// - mode strap picks direct or polled sharing
// - few queues, direct mode: bits 0-7 shown continuously
// - strobe latches address bit zero as sector
// - new sector visible one clock later
// - unconfigured upper-sector outputs are don't care
// - sector-switch lag allowed, active flag exact
// - top address bits must match identity
// - polled mode steps sector every clock; with eight or fewer queues the code pins the shown sector to zero
// - marker high during first sector only
// - master drives first, four clocks total
// - token passes around a ring
`timescale 1ns/1ps
module afsb_top
    import afsb_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wr_en,
    input wire logic queue_select,
    input wire logic [7:0] write_queue_address,
    input wire logic sector_strobe,
    input wire logic rd_en,
    input wire logic [3:0] rd_queue,
    input wire logic flag_bus_mode_select,
    input wire logic default_offset_select,
    input wire logic master_device_select,
    input wire logic [2:0] device_identity_pins,
    input wire logic token_in,
    output logic almost_full_flag,
    output logic [7:0] almost_full_status_bus,
    output logic almost_full_status_bus_oe,
    output logic first_sector_marker,
    output logic token_out
);
    // straps captured while reset is held
    logic fm_ff; // high: polled bus sharing
    logic df_ff; // default offset choice
    logic master_device_select_ff; // this device starts the ring
    logic [2:0] id_ff; // identity for address match

    // configuration from the register file
    logic [4:0] num_queues;
    logic [1:0] width_mode;
    logic [15:0] depth;
    logic [15:0] offset_val;
    logic offset_use;
    logic [31:0] status_word; // read back over apb

    // write port selection and direct sector
    logic [3:0] wq_ff; // queue selected for writing
    logic wsel_ff; // selection targets this device
    logic sector_ff; // direct-mode sector
    logic own_ff; // direct-mode bus ownership
    logic addr_match; // identity bits match
    logic few_q; // eight or fewer queues

    // per-queue state
    logic [LVL_W-1:0] level_ff [NUM_Q]; // words held
    logic [NUM_Q-1:0] half_ff; // half-word read pending
    logic [NUM_Q-1:0] both_ff; // read port on queue at first word
    logic [NUM_Q-1:0] raw; // level at or past threshold
    logic [NUM_Q-1:0] s1_ff; // raw delayed one clock
    logic [NUM_Q-1:0] af_now; // almost full as shown outward
    logic [15:0] m_off; // almost-full offset in use

    // polled sequencer hooks
    logic poll_drive;
    logic poll_sector;
    logic bus_sector; // sector feeding the bus flop

    // threshold in write words for one queue
    function automatic logic [THR_W-1:0] afsb_thr(
        input logic [1:0] wm,
        input logic both,
        input logic [15:0] d,
        input logic [15:0] m
    );
        logic [THR_W-1:0] base_both;
        logic [THR_W-1:0] base_wo;
        logic [THR_W-1:0] t;
        base_both = {2'b00, d} + 18'h0_0001 - {2'b00, m};
        base_wo = {2'b00, d} - {2'b00, m};
        case (wm)
            WM_18_TO_9: t = base_wo;
            WM_9_TO_18: begin
                // two narrow writes fill one wide word
                t = both ? {base_both[THR_W-2:0], 1'b0} : {base_wo[THR_W-2:0], 1'b0};
            end
            default: t = both ? base_both : base_wo;
        endcase
        // never let a zero threshold flag an empty queue
        if (t == 18'h0_0000) begin
            t = 18'h0_0001;
        end
        return t;
    endfunction

    // register file over apb
    afsb_apb_regs u_regs (
        .clock(clock),
        .srst(srst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status_in(status_word),
        .num_queues(num_queues),
        .width_mode(width_mode),
        .depth(depth),
        .offset_val(offset_val),
        .offset_use(offset_use)
    );

    // token ring sequencer for polled sharing
    afsb_poll_ring u_poll (
        .clock(clock),
        .srst(srst),
        .enable(fm_ff),
        .master(master_device_select_ff),
        .token_in(token_in),
        .nxt_drive(poll_drive),
        .nxt_sector(poll_sector),
        .token_out(token_out),
        .first_sector_marker(first_sector_marker)
    );

    // status readback: live almost-full vector plus bus state
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[NUM_Q-1:0] = af_now;
        status_word[STATUS_SEC_BIT] = sector_ff;
        status_word[STATUS_OWN_BIT] = own_ff;
    end

    // straps: sampled every cycle of reset, frozen after release
    always_ff @(posedge clock) begin
        if (srst) begin
            fm_ff <= flag_bus_mode_select;
            df_ff <= default_offset_select;
            master_device_select_ff <= master_device_select;
            id_ff <= device_identity_pins;
        end
    end

    // offset: software override, else the strapped default
    assign m_off = offset_use ? offset_val : (df_ff ? OFFSET_HIGH : OFFSET_LOW);

    // identity lives in the top three address bits
    assign addr_match = (write_queue_address[7:5] == id_ff);
    assign few_q = (num_queues <= FEW_Q_MAX);

    // write queue selection
    always_ff @(posedge clock) begin
        if (srst) begin
            wq_ff <= 4'h0;
            wsel_ff <= 1'b0;
        end else if (queue_select) begin
            wq_ff <= write_queue_address[3:0];
            wsel_ff <= addr_match;
        end
    end

    // direct sector selection; a queue select in the same cycle wins
    // since the two share the address bus and cannot both be meant
    always_ff @(posedge clock) begin
        if (srst) begin
            sector_ff <= 1'b0;
            own_ff <= 1'b0;
        end else if (~fm_ff & sector_strobe & ~queue_select) begin
            sector_ff <= write_queue_address[0];
            own_ff <= addr_match;
        end
    end

    // per-queue fill level and almost-full detection
    genvar q;
    generate
        for (q = 0; q < NUM_Q; q++) begin : g_q
            logic wr_hit;
            logic rd_hit;
            logic [1:0] dec;
            logic [LVL_W-1:0] lvl;

            assign lvl = level_ff[q];
            assign wr_hit = wr_en & wsel_ff & (wq_ff == q[3:0]) & (lvl != {LVL_W{1'b1}});
            assign rd_hit = rd_en & (rd_queue == q[3:0]) & (lvl != {LVL_W{1'b0}});

            // words removed by one read, by bus matching
            always_comb begin
                dec = 2'h1;
                case (width_mode)
                    WM_18_TO_9: dec = {1'b0, half_ff[q]};
                    WM_9_TO_18: dec = (lvl == 17'h0_0001) ? 2'h1 : 2'h2;
                    default: dec = 2'h1;
                endcase
                if (~rd_hit) begin
                    dec = 2'h0;
                end
            end

            // level counter; empty queue reads are ignored
            always_ff @(posedge clock) begin
                if (srst) begin
                    level_ff[q] <= 17'h0_0000;
                end else begin
                    level_ff[q] <= lvl + {16'h0000, wr_hit} - {15'h0000, dec};
                end
            end

            // narrow reads take half a word each
            always_ff @(posedge clock) begin
                if (srst) begin
                    half_ff[q] <= 1'b0;
                end else if (rd_hit & (width_mode == WM_18_TO_9)) begin
                    half_ff[q] <= ~half_ff[q];
                end
            end

            // note whether reads were aimed here when the first word came in
            always_ff @(posedge clock) begin
                if (srst) begin
                    both_ff[q] <= 1'b0;
                end else if (wr_hit & (lvl == 17'h0_0000)) begin
                    both_ff[q] <= (rd_queue == q[3:0]);
                end
            end

            assign raw[q] = ({1'b0, lvl} >= afsb_thr(width_mode, both_ff[q], depth, m_off));

            // delay stage: setting takes an extra clock, clearing does not
            always_ff @(posedge clock) begin
                if (srst) begin
                    s1_ff[q] <= 1'b0;
                end else begin
                    s1_ff[q] <= raw[q];
                end
            end

            // needs both stages to assert, either to release
            assign af_now[q] = s1_ff[q] & raw[q];
        end
    endgenerate

    // active write-port flag, low when the selected queue is almost full
    // flag follows the live selection, so it is exact across switches
    always_ff @(posedge clock) begin
        if (srst) begin
            almost_full_flag <= 1'b1;
        end else begin
            almost_full_flag <= ~(wsel_ff & af_now[wq_ff]);
        end
    end

    // sector to present: polled steps, direct latches, few queues pin to zero
    always_comb begin
        bus_sector = fm_ff ? poll_sector : sector_ff;
        if (few_q) begin
            bus_sector = 1'b0;
        end
    end

    // status bus bits, one per queue of the presented sector
    generate
        for (q = 0; q < SEC_W; q++) begin : g_bit
            logic [4:0] idx;
            assign idx = {1'b0, bus_sector, q[2:0]};
            always_ff @(posedge clock) begin
                if (srst) begin
                    almost_full_status_bus[q] <= 1'b1;
                end else if (idx < num_queues) begin
                    // an access racing a sector switch may lag a clock here
                    almost_full_status_bus[q] <= ~af_now[idx[3:0]];
                end else begin
                    // unconfigured queues: park high
                    almost_full_status_bus[q] <= 1'b1;
                end
            end
        end
    endgenerate

    // bus drive enable; a shared bus is released while another owns it
    always_ff @(posedge clock) begin
        if (srst) begin
            almost_full_status_bus_oe <= 1'b0;
        end else if (fm_ff) begin
            // small single setups are best run polled, no address needed
            almost_full_status_bus_oe <= poll_drive;
        end else if (few_q) begin
            almost_full_status_bus_oe <= 1'b1;
        end else begin
            almost_full_status_bus_oe <= own_ff;
        end
    end

    // rule-seven allowance is not used: switches cost no extra clock
    // which stays inside the permitted lag of the bus bits
endmodule

/* File: verilog/afsb_pkg.sv */
package afsb_pkg;
    // queue and bus geometry
    localparam int NUM_Q = 16;
    localparam int SEC_W = 8;
    localparam int LVL_W = 17;
    localparam int THR_W = 18;
    localparam logic [4:0] FEW_Q_MAX = 5'h08;
    // default almost-full offsets picked by the offset strap
    localparam logic [15:0] OFFSET_LOW = 16'h0008;
    localparam logic [15:0] OFFSET_HIGH = 16'h0080;
    // bus matching modes
    localparam logic [1:0] WM_EQUAL = 2'h0;
    localparam logic [1:0] WM_18_TO_9 = 2'h1;
    localparam logic [1:0] WM_9_TO_18 = 2'h2;
    // apb register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_DEPTH = 12'h004;
    localparam logic [11:0] REG_OFFSET = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    // field positions
    localparam int CTRL_NQ_LSB = 0;
    localparam int CTRL_WM_LSB = 8;
    localparam int OFFSET_USE_BIT = 16;
    localparam int STATUS_SEC_BIT = 16;
    localparam int STATUS_OWN_BIT = 17;
    // reset values
    localparam logic [4:0] NQ_RST = 5'h10;
    localparam logic [1:0] WM_RST = 2'h0;
    localparam logic [15:0] DEPTH_RST = 16'h0800;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    // polled ownership lasts four write clocks: first cycle plus three more
    localparam logic [1:0] POLL_LAST = 2'h3;
    // polled sequencer states
    typedef enum logic {PS_IDLE, PS_DRIVE} afsb_poll_t;
endpackage

/* File: verilog/afsb_apb_regs.sv */
`timescale 1ns/1ps
module afsb_apb_regs
    import afsb_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] status_in,
    output logic [4:0] num_queues,
    output logic [1:0] width_mode,
    output logic [15:0] depth,
    output logic [15:0] offset_val,
    output logic offset_use
);
    logic [31:0] rd_mux; // read data chosen in setup
    logic hit; // address maps to a register
    logic wr_go; // write completes this edge

    // decode; reserved bits read zero
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            REG_CTRL: begin
                rd_mux[CTRL_NQ_LSB +: 5] = num_queues;
                rd_mux[CTRL_WM_LSB +: 2] = width_mode;
            end
            REG_DEPTH: rd_mux[15:0] = depth;
            REG_OFFSET: begin
                rd_mux[15:0] = offset_val;
                rd_mux[OFFSET_USE_BIT] = offset_use;
            end
            REG_STATUS: rd_mux = status_in;
            default: hit = 1'b0;
        endcase
    end

    assign wr_go = psel & penable & pready & pwrite & ~pslverr;

    // one wait-free answer: pready rises in the access cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // configuration registers; meant to be set before traffic starts
    always_ff @(posedge clock) begin
        if (srst) begin
            num_queues <= NQ_RST;
            width_mode <= WM_RST;
            depth <= DEPTH_RST;
            offset_val <= OFFSET_RST;
            offset_use <= 1'b0;
        end else if (wr_go) begin
            if (paddr == REG_CTRL) begin
                num_queues <= pwdata[CTRL_NQ_LSB +: 5];
                width_mode <= pwdata[CTRL_WM_LSB +: 2];
            end
            if (paddr == REG_DEPTH) begin
                depth <= pwdata[15:0];
            end
            if (paddr == REG_OFFSET) begin
                offset_val <= pwdata[15:0];
                offset_use <= pwdata[OFFSET_USE_BIT];
            end
        end
    end
endmodule

/* File: verilog/afsb_poll_ring.sv */
`timescale 1ns/1ps
module afsb_poll_ring
    import afsb_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic enable,
    input wire logic master,
    input wire logic token_in,
    output logic nxt_drive,
    output logic nxt_sector,
    output logic token_out,
    output logic first_sector_marker
);
    afsb_poll_t state_ff; // owning the bus or waiting
    afsb_poll_t nxt_state;
    logic [1:0] cnt_ff; // cycle within ownership
    logic [1:0] nxt_cnt;
    logic start_ff; // master kick-off after reset release

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            PS_IDLE: begin
                if (enable & ((start_ff & master) | token_in)) begin
                    nxt_state = PS_DRIVE;
                    nxt_cnt = 2'h0;
                end
            end
            PS_DRIVE: begin
                if (cnt_ff == POLL_LAST) begin
                    // a looped-back token keeps a lone device cycling
                    if (token_in) begin
                        nxt_cnt = 2'h0;
                    end else begin
                        nxt_state = PS_IDLE;
                    end
                end else begin
                    nxt_cnt = cnt_ff + 2'h1;
                end
            end
            default: nxt_state = PS_IDLE;
        endcase
    end

    assign nxt_drive = (nxt_state == PS_DRIVE);
    assign nxt_sector = nxt_cnt[0];

    // state, token and marker flops
    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff <= PS_IDLE;
            cnt_ff <= 2'h0;
            start_ff <= 1'b1;
            token_out <= 1'b0;
            first_sector_marker <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            start_ff <= 1'b0;
            // token leaves in the last owned cycle so the next device follows gaplessly
            token_out <= nxt_drive & (nxt_cnt == POLL_LAST);
            first_sector_marker <= nxt_drive & ~nxt_cnt[0];
        end
    end
endmodule

/* File: testbench/afsb_top_props.sv */
`timescale 1ns/1ps
module afsb_props (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic rd_en,
    input wire logic queue_select,
    input wire logic [7:0] write_queue_address,
    input wire logic sector_strobe,
    input wire logic flag_bus_mode_select,
    input wire logic [2:0] device_identity_pins,
    input wire logic token_in,
    input wire logic almost_full_flag,
    input wire logic [7:0] almost_full_status_bus,
    input wire logic almost_full_status_bus_oe,
    input wire logic first_sector_marker,
    input wire logic token_out
);
    // single write clock domain
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // the flag, status bus, drive enable, marker, token and pready must come out of reset idle
    AST_RESET_QUIET:
    assert property ($fell(srst) |-> almost_full_flag && almost_full_status_bus == 8'hFF
        && !almost_full_status_bus_oe && !first_sector_marker && !token_out && !pready) else $error("not idle");
    // slave answers in the cycle after setup, for one cycle only
    AST_READY_NEXT:
    assert property (psel && !penable |=> pready) else $error("no ready");
    AST_READY_ONE:
    assert property (pready |=> !pready) else $error("ready held");
    // the marker only ever shows while this device owns the bus
    AST_MARK_OWNS:
    assert property (first_sector_marker |-> almost_full_status_bus_oe) else $error("marker unowned");
    AST_SECTOR_STEP:
    assert property (first_sector_marker |=> !first_sector_marker && almost_full_status_bus_oe) else $error("no step");
    // token leaves only in the fourth owned cycle
    AST_TOKEN_LATE:
    assert property ($rose(token_out) |-> $past(first_sector_marker) && $past(first_sector_marker, 3))
        else $error("token early");
    AST_TOKEN_ONE:
    assert property (token_out |=> !token_out) else $error("token held");
    AST_TOKEN_TAKE:
    assert property (flag_bus_mode_select && token_in && (token_out || !almost_full_status_bus_oe)
        |=> first_sector_marker) else $error("token ignored");
    // the active flag only releases after a read, a reselection or new settings
    AST_FLAG_RISE:
    assert property ($rose(almost_full_flag) |-> $past(rd_en, 2) || $past(queue_select, 2)
        || $past(queue_select, 3) || $past(psel, 2) || $past(psel, 3)) else $error("flag rose alone");
    AST_DIRECT_OWN:
    assert property (!flag_bus_mode_select && sector_strobe && !queue_select
        && write_queue_address[7:5] == device_identity_pins |-> ##2 almost_full_status_bus_oe) else $error("no own");
endmodule
bind afsb_top afsb_props props_u (.clock, .srst, .psel, .penable, .pready, .rd_en, .queue_select,
    .write_queue_address, .sector_strobe, .flag_bus_mode_select, .device_identity_pins, .token_in,
    .almost_full_flag, .almost_full_status_bus, .almost_full_status_bus_oe, .first_sector_marker, .token_out);

/* File: testbench/afsb_ctrl_model.sv */
`timescale 1ns/1ps
module afsb_ctrl_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic solo,
    input wire logic token_out,
    output logic token_in
);
    // peer ownership counter; the peer is slow on purpose: four full cycles
    logic [2:0] peer_cnt_ff;
    // a lone device has its token looped straight back
    assign token_in = solo ? token_out : (peer_cnt_ff == 3'h4);
    // peer takes the token, owns the bus four cycles, then hands it back
    always_ff @(posedge clock) begin
        if (srst) begin
            peer_cnt_ff <= 3'h0;
        end else if (token_out && !solo) begin
            peer_cnt_ff <= 3'h1;
        end else if (peer_cnt_ff != 3'h0) begin
            peer_cnt_ff <= (peer_cnt_ff == 3'h4) ? 3'h0 : peer_cnt_ff + 3'h1;
        end
    end
endmodule

/* File: testbench/almost_full_flag_status_bus_tb.sv */
`timescale 1ns/1ps
module almost_full_flag_status_bus_tb
    import afsb_pkg::*;
;
    logic clock, srst, psel, penable, pwrite, wr_en, queue_select, sector_strobe, rd_en, solo;
    logic flag_bus_mode_select, default_offset_select, master_device_select, token_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, almost_full_flag, almost_full_status_bus_oe, first_sector_marker, token_out;
    logic [7:0] write_queue_address, almost_full_status_bus;
    logic [3:0] rd_queue;
    logic [2:0] device_identity_pins;
    int error_cnt = 0;
    int samples_checked = 0;
    afsb_top dut_u (.*);
    afsb_ctrl_model ring_u (.clock, .srst, .solo, .token_out, .token_in);
    // 25 MHz write clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ring_state();
        return {29'h0, almost_full_status_bus_oe, first_sector_marker, token_out};
    endfunction
    // straps are only taken while reset is high
    task automatic do_reset(input logic fm, input logic df, input logic ms, input logic lone);
        srst <= 1'b1;
        flag_bus_mode_select <= fm;
        default_offset_select <= df;
        master_device_select <= ms;
        solo <= lone;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
    endtask
    // one transfer, held until pready is seen; an idle cycle follows so psel is never set twice at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask
    // n writes into empty queue q; flag and shown bus bit must fall exactly two edges after the last
    task automatic fill(input logic [3:0] q, input logic both, input int n, input logic shown);
        write_queue_address <= {4'hA, q};
        queue_select <= 1'b1;
        rd_queue <= both ? q : q + 4'h1;
        @(posedge clock);
        queue_select <= 1'b0;
        wr_en <= 1'b1;
        repeat (n) @(posedge clock);
        wr_en <= 1'b0;
        repeat (2) @(posedge clock);
        chk({30'h0, almost_full_status_bus[q[2:0]] | ~shown, almost_full_flag}, 32'h3);
        @(posedge clock);
        chk({30'h0, almost_full_status_bus[q[2:0]] & shown, almost_full_flag}, 32'h0);
    endtask
    // top address bits carry the device identity, bit zero the sector
    task automatic sector(input logic [2:0] dev, input logic sec, input logic also_q, input logic [8:0] exp);
        write_queue_address <= {dev, 4'h0, sec};
        sector_strobe <= 1'b1;
        queue_select <= also_q;
        @(posedge clock);
        sector_strobe <= 1'b0;
        queue_select <= 1'b0;
        repeat (2) @(posedge clock);
        chk({23'h0, almost_full_status_bus_oe, almost_full_status_bus | {8{~exp[8]}}}, {23'h0, exp});
    endtask
    task automatic t_regs;
        do_reset(1'b0, 1'b0, 1'b0, 1'b1);
        rd_chk(REG_CTRL, {22'h0, WM_RST, 3'h0, NQ_RST}, 1'b0);
        rd_chk(REG_DEPTH, {16'h0, DEPTH_RST}, 1'b0);
        rd_chk(REG_OFFSET, {16'h0, OFFSET_RST}, 1'b0);
        rd_chk(12'h010, 32'h0, 1'b1);
        wr(REG_OFFSET, 32'h0001_0005);
        rd_chk(REG_OFFSET, 32'h0001_0005, 1'b0);
        $display("test regs done");
    endtask
    // depth 16, offset 8: equal widths with and without the read port on the queue, 18to9 without it, 9to18 with it
    task automatic t_thresh;
        logic [1:0] wm [4] = '{WM_EQUAL, WM_EQUAL, WM_18_TO_9, WM_9_TO_18};
        int cnt [4] = '{8, 9, 8, 18};
        do_reset(1'b0, 1'b0, 1'b0, 1'b1);
        wr(REG_DEPTH, 32'h0000_0010);
        sector(3'h5, 1'b0, 1'b0, 9'h1FF);
        for (int i = 0; i < 4; i++) begin
            wr(REG_CTRL, {22'h0, wm[i], 8'h10});
            fill(i[3:0], i[0], cnt[i], 1'b1);
        end
        rd_queue <= 4'h3;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(posedge clock);
        chk({30'h0, almost_full_status_bus[3], almost_full_flag}, 32'h0);
        @(posedge clock);
        chk({30'h0, almost_full_status_bus[3], almost_full_flag}, 32'h3);
        $display("test thresholds done");
    endtask
    // strapped offset 128, sector switching, refused strobe, foreign identity, few queues
    task automatic t_direct;
        do_reset(1'b0, 1'b1, 1'b0, 1'b1);
        wr(REG_DEPTH, 32'h0000_00C8);
        sector(3'h5, 1'b0, 1'b0, 9'h1FF);
        fill(4'h0, 1'b0, 72, 1'b1);
        sector(3'h5, 1'b1, 1'b0, 9'h1FF);
        sector(3'h5, 1'b0, 1'b0, 9'h1FE);
        sector(3'h5, 1'b1, 1'b1, 9'h1FE);
        sector(3'h2, 1'b1, 1'b0, 9'h0FF);
        wr(REG_CTRL, 32'h0000_0008);
        sector(3'h5, 1'b1, 1'b0, 9'h1FE);
        sector(3'h2, 1'b1, 1'b0, 9'h1FE);
        $display("test direct done");
    endtask
    // polled master, first alone on a looped token, then with a slow peer in the ring
    task automatic t_polled;
        int n;
        do_reset(1'b1, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            chk(ring_state(), {29'h0, 1'b1, i % 2 == 0, i % 4 == 3});
        end
        wr(REG_DEPTH, 32'h0000_0010);
        fill(4'h8, 1'b0, 8, 1'b0);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (first_sector_marker !== 1'b1 && n < 8);
        for (int i = 0; i < 4; i++) begin
            chk({30'h0, first_sector_marker, almost_full_status_bus[0]}, {30'h0, {2{i % 2 == 0}}});
            @(posedge clock);
        end
        do_reset(1'b1, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            chk(ring_state(), {29'h0, i % 8 < 4, i % 8 == 0 || i % 8 == 2, i % 8 == 3});
        end
        $display("test polled done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wr_en = 1'b0;
        queue_select = 1'b0;
        write_queue_address = 8'h00;
        sector_strobe = 1'b0;
        rd_en = 1'b0;
        rd_queue = 4'h0;
        flag_bus_mode_select = 1'b0;
        default_offset_select = 1'b0;
        master_device_select = 1'b0;
        device_identity_pins = 3'h5;
        solo = 1'b1;
        t_regs;
        t_thresh;
        t_direct;
        t_polled;
        tally_and_finish;
    end
    // the tests need well under a thousand cycles; a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        tally_and_finish;
    end
endmodule
